// >>> pdwg_pkg.sv
package pdwg_pkg;
  // ----------------------------------------
  // Peripheral address decode
  // ----------------------------------------
  localparam int          ADDR_W                  = 16;
  localparam int          DATA_W                  = 16;
  localparam int          PERIPH_SEL_POS          = 14;
  localparam int          DEV_SEL_POS             = 2;
  localparam int          CHAN_LO_POS             = 0;
  localparam int          CHAN_HI_POS             = 1;
  localparam logic [15:0] DAC_BASE_ADDR           = 16'h4000;
  localparam logic [15:0] DAC_LAST_ADDR           = 16'h4007;
  localparam int          NUM_DAC_DEV             = 2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int          CLK_PERIOD_PS           = 10000;
  localparam int          CS_PULSE_NS             = 75;
  localparam int          CS_PULSE_CYC            = (CS_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
                                                    / CLK_PERIOD_PS;
  localparam int          LOAD_GAP_US             = 80;
  localparam int          LOAD_GAP_CYC            = (LOAD_GAP_US * 1000000 + CLK_PERIOD_PS - 1)
                                                    / CLK_PERIOD_PS;
  localparam int          CNT_W                   = 16;
  // ----------------------------------------
  // Buffering and resets
  // ----------------------------------------
  localparam int          FIFO_DEPTH              = 16;
  localparam int          FIFO_W                  = 3 + DATA_W;
  localparam logic        CS_IDLE                 = 1'b1;
  localparam logic [1:0]  MODE_SERIAL_AMP         = 2'h0;
  localparam logic [1:0]  MODE_PARALLEL_DAC       = 2'h1;

  typedef enum logic [1:0] {
    PDWG_IDLE  = 2'b00,
    PDWG_PULSE = 2'b01,
    PDWG_GAP   = 2'b10
  } pdwg_state_t;
endpackage

// >>> pdwg_fifo.sv
module pdwg_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;
  logic [AW:0]      used;

  assign used      = wr_ptr_r - rd_ptr_r;
  // Output register holds one of the words, so the total stays at DEPTH
  assign full      = (used == (AW+1)'(DEPTH))
                  || (out_valid && (used == (AW+1)'(DEPTH - 1)));
  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign in_ready  = !full;
  assign push      = in_valid && !full;
  assign pop       = out_ready && out_valid;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (clk_en && push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
    end else if (clk_en && push) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  // Registered read data, refilled whenever the output slot empties
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_ptr_r  <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (clk_en) begin
      if (!empty && (!out_valid || pop)) begin
        out_data  <= mem_r[rd_ptr_r[AW-1:0]];
        out_valid <= 1'b1;
        rd_ptr_r  <= rd_ptr_r + 1'b1;
      end else if (pop) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

// >>> pdwg_dac_glue.sv
module pdwg_dac_glue
  import pdwg_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              buffered_system_clock,
  input  wire logic              host_write_strobe_n,
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic [DATA_W-1:0] host_data,
  input  wire logic              init_hold_n,
  input  wire logic              output_kind_strap_0,
  input  wire logic              host_amp_select_n,
  input  wire logic              host_amp_enable_n,
  input  wire logic              amp_fault_flag,
  output logic                   write_ready,
  output logic [NUM_DAC_DEV-1:0] dac_cs_n,
  output logic [1:0]             dac_chan_addr,
  output logic [DATA_W-1:0]      dac_data,
  output logic                   dac_load_strobe_n,
  output logic                   amp_serial_select_n,
  output logic                   amp_enable_n,
  output logic                   amp_fault_seen,
  output logic [1:0]             output_kind
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0]        clk_sync_r;
  logic [1:0]        wr_sync_r;
  logic [1:0]        hold_sync_r;
  logic [1:0]        strap_sync_r;
  logic [1:0]        fault_sync_r;
  logic [1:0]        amp_sel_sync_r;
  logic [1:0]        amp_en_sync_r;
  logic [ADDR_W-1:0] addr_m_r;
  logic [ADDR_W-1:0] addr_s_r;
  logic [DATA_W-1:0] data_m_r;
  logic [DATA_W-1:0] data_s_r;
  logic              clk_prev_r;
  logic              wr_low_seen_r;

  // Idle levels preloaded so reset release makes no false edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clk_sync_r     <= 2'h0;
      wr_sync_r      <= 2'h3;
      hold_sync_r    <= 2'h0;
      strap_sync_r   <= 2'h0;
      fault_sync_r   <= 2'h0;
      amp_sel_sync_r <= 2'h3;
      amp_en_sync_r  <= 2'h3;
    end else if (clk_en) begin
      clk_sync_r     <= {clk_sync_r[0], buffered_system_clock};
      wr_sync_r      <= {wr_sync_r[0], host_write_strobe_n};
      hold_sync_r    <= {hold_sync_r[0], init_hold_n};
      strap_sync_r   <= {strap_sync_r[0], output_kind_strap_0};
      fault_sync_r   <= {fault_sync_r[0], amp_fault_flag};
      amp_sel_sync_r <= {amp_sel_sync_r[0], host_amp_select_n};
      amp_en_sync_r  <= {amp_en_sync_r[0], host_amp_enable_n};
    end
  end

  // Address and data resynced per bit; the strobe must bracket a stable word
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_m_r <= '0;
      addr_s_r <= '0;
      data_m_r <= '0;
      data_s_r <= '0;
    end else if (clk_en) begin
      addr_m_r <= host_addr;
      addr_s_r <= addr_m_r;
      data_m_r <= host_data;
      data_s_r <= data_m_r;
    end
  end

  // ----------------------------------------
  // Write capture on clock-output rising edge
  // ----------------------------------------
  logic clk_rise;
  logic wr_sample;
  logic in_dac_space;
  logic in_valid;
  logic in_ready;

  assign clk_rise = clk_sync_r[1] && !clk_prev_r;
  assign wr_sample = clk_rise && !wr_sync_r[1];
  assign in_dac_space = addr_s_r[PERIPH_SEL_POS]
                     && (addr_s_r >= DAC_BASE_ADDR) && (addr_s_r <= DAC_LAST_ADDR);
  // One capture per strobe low period, ignored during hold
  // No capture in hold
  assign in_valid = wr_sample && !wr_low_seen_r && in_dac_space && hold_sync_r[1];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clk_prev_r    <= 1'b0;
      wr_low_seen_r <= 1'b0;
    end else if (clk_en) begin
      clk_prev_r <= clk_sync_r[1];
      if (wr_sync_r[1]) begin
        wr_low_seen_r <= 1'b0;
      end else if (wr_sample) begin
        wr_low_seen_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Write queue
  // ----------------------------------------
  logic              q_valid;
  logic              q_ready;
  logic [FIFO_W-1:0] q_data;

  pdwg_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) pdwg_fifo_i (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({addr_s_r[DEV_SEL_POS], addr_s_r[CHAN_HI_POS], addr_s_r[CHAN_LO_POS],
                 data_s_r}),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      write_ready <= 1'b0;
    end else if (clk_en) begin
      write_ready <= in_ready;
    end
  end

  // ----------------------------------------
  // Select pulse sequencer
  // ----------------------------------------
  pdwg_state_t state_r;
  pdwg_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic             cur_dev_r;
  logic             cur_load_r;

  // Queue drains only when idle, so a long gap back-pressures writes
  assign q_ready = (state_r == PDWG_IDLE) && hold_sync_r[1];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PDWG_IDLE: begin
        if (q_valid && q_ready) begin
          state_nxt = PDWG_PULSE;
        end
      end
      PDWG_PULSE: begin
        if (cnt_r == CNT_W'(CS_PULSE_CYC - 1)) begin
          state_nxt = cur_load_r ? PDWG_GAP : PDWG_IDLE;
        end
      end
      PDWG_GAP: begin
        if (cnt_r == CNT_W'(LOAD_GAP_CYC - 1)) begin
          state_nxt = PDWG_IDLE;
        end
      end
      default: state_nxt = PDWG_IDLE;
    endcase
    if (!hold_sync_r[1]) begin
      state_nxt = PDWG_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= PDWG_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Counter restarts on every state change
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      cnt_r <= (state_nxt == state_r) ? cnt_r + 1'b1 : '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur_dev_r  <= 1'b0;
      cur_load_r <= 1'b0;
    end else if (clk_en && q_valid && q_ready) begin
      cur_dev_r  <= q_data[DATA_W+2];
      cur_load_r <= !q_data[DATA_W];
    end
  end

  // Channel and data stand from select fall until the next write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dac_chan_addr <= 2'h0;
      dac_data      <= '0;
    end else if (clk_en && q_valid && q_ready) begin
      dac_chan_addr <= q_data[DATA_W+1:DATA_W];
      dac_data      <= q_data[DATA_W-1:0];
    end
  end

  // ----------------------------------------
  // Select and load outputs
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_DAC_DEV; g++) begin : g_cs
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          dac_cs_n[g] <= CS_IDLE;
        end else if (clk_en) begin
          dac_cs_n[g] <= !((state_nxt == PDWG_PULSE) && hold_sync_r[1]
                        && (((state_r == PDWG_IDLE) ? q_data[DATA_W+2] : cur_dev_r)
                            == 1'(g)));
        end
      end
    end
  endgenerate

  // Load pulse follows the phase A select, one per axis
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dac_load_strobe_n <= 1'b1;
    end else if (clk_en) begin
      dac_load_strobe_n <= !((state_nxt == PDWG_GAP) && (state_r == PDWG_PULSE));
    end
  end

  // ----------------------------------------
  // Amplifier hooks
  // ----------------------------------------
  // Select only in serial mode; off in hold, where the mode may change
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      amp_serial_select_n <= 1'b1;
    end else if (clk_en) begin
      amp_serial_select_n <= amp_sel_sync_r[1] || (output_kind != MODE_SERIAL_AMP)
                             || !hold_sync_r[1];
    end
  end

  // Enable low only when fault free
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      amp_enable_n <= 1'b1;
    end else if (clk_en) begin
      amp_enable_n <= amp_en_sync_r[1] || fault_sync_r[1] || !hold_sync_r[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      amp_fault_seen <= 1'b0;
    end else if (clk_en) begin
      amp_fault_seen <= fault_sync_r[1];
    end
  end

  // ----------------------------------------
  // Output kind strap
  // ----------------------------------------
  // Strap caught during hold
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      output_kind <= MODE_SERIAL_AMP;
    end else if (clk_en && !hold_sync_r[1]) begin
      output_kind <= strap_sync_r[1] ? MODE_PARALLEL_DAC : MODE_SERIAL_AMP;
    end
  end
endmodule

// >>> pdwg_dac_glue_monitor.sv
module pdwg_dac_glue_monitor
  import pdwg_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              init_hold_n,
  input wire logic              amp_fault_flag,
  input wire logic [1:0]        dac_cs_n,
  input wire logic [1:0]        dac_chan_addr,
  input wire logic [DATA_W-1:0] dac_data,
  input wire logic              dac_load_strobe_n,
  input wire logic              amp_serial_select_n,
  input wire logic              amp_enable_n,
  input wire logic              amp_fault_seen,
  input wire logic [1:0]        output_kind
);
  timeunit 1ns;
  timeprecision 100ps;
  int gap_cnt_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // Gap counter
  // ----
  // Starts full so the first select after reset is legal
  always_ff @(posedge ref_clk) begin
    if (!rst_n) gap_cnt_r <= LOAD_GAP_CYC;
    else if (!dac_load_strobe_n) gap_cnt_r <= 0;
    else if (gap_cnt_r < LOAD_GAP_CYC) gap_cnt_r <= gap_cnt_r + 1;
  end
  property p_cs_hold;
    !init_hold_n [*4] |-> &dac_cs_n;
  endproperty
  property p_cs_one;
    dac_cs_n != 2'h0;
  endproperty
  property p_cs_width;
    $fell(&dac_cs_n) |-> !(&dac_cs_n) [*8] ##1 &dac_cs_n;
  endproperty
  property p_load_pos;
    $fell(dac_load_strobe_n) |-> $rose(&dac_cs_n) && !dac_chan_addr[0];
  endproperty
  property p_load_one;
    !dac_load_strobe_n |=> dac_load_strobe_n;
  endproperty
  property p_gap;
    $fell(&dac_cs_n) |-> gap_cnt_r >= LOAD_GAP_CYC;
  endproperty
  property p_stable;
    !(&dac_cs_n) && !$fell(&dac_cs_n) |-> $stable(dac_data) && $stable(dac_chan_addr);
  endproperty
  property p_sel_mode;
    !amp_serial_select_n |-> output_kind == MODE_SERIAL_AMP;
  endproperty
  property p_en_fault;
    amp_fault_seen [*2] |-> amp_enable_n;
  endproperty
  property p_fault;
    amp_fault_flag [*4] |-> amp_fault_seen;
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("select during hold");
  a_cs_one: assert property (p_cs_one) else $error("both selects low");
  a_cs_width: assert property (p_cs_width) else $error("select width");
  a_load_pos: assert property (p_load_pos) else $error("load placement");
  a_load_one: assert property (p_load_one) else $error("load too long");
  a_gap: assert property (p_gap) else $error("load gap short");
  a_stable: assert property (p_stable) else $error("data moved");
  a_sel_mode: assert property (p_sel_mode) else $error("select in mode");
  a_en_fault: assert property (p_en_fault) else $error("enable on fault");
  a_fault: assert property (p_fault) else $error("fault missed");
  c_load: cover property ($fell(dac_load_strobe_n));
  c_dev1: cover property ($fell(dac_cs_n[1]));
  c_fault: cover property ($rose(amp_fault_seen));
endmodule
bind pdwg_dac_glue pdwg_dac_glue_monitor pdwg_dac_glue_monitor_i (
  .ref_clk             (ref_clk),
  .rst_n               (rst_n),
  .init_hold_n         (init_hold_n),
  .amp_fault_flag      (amp_fault_flag),
  .dac_cs_n            (dac_cs_n),
  .dac_chan_addr       (dac_chan_addr),
  .dac_data            (dac_data),
  .dac_load_strobe_n   (dac_load_strobe_n),
  .amp_serial_select_n (amp_serial_select_n),
  .amp_enable_n        (amp_enable_n),
  .amp_fault_seen      (amp_fault_seen),
  .output_kind         (output_kind)
);

// >>> pdwg_dac_model.sv
module pdwg_dac_model
  import pdwg_pkg::*;
(
  input  wire logic [1:0]        dac_cs_n,
  input  wire logic [1:0]        dac_chan_addr,
  input  wire logic [DATA_W-1:0] dac_data,
  input  wire logic              dac_load_strobe_n,
  input  wire logic              fault_req,
  output logic                   amp_fault_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] buf_r [8];
  logic [15:0] out_r [8];
  int          wr_cnt = 0;
  int          ld_cnt = 0;
  // ----
  // Converter pair
  // ----
  // device and channel latch
  always @(posedge dac_cs_n[0]) begin
    buf_r[{1'b0, dac_chan_addr}] = dac_data;
    wr_cnt++;
  end
  always @(posedge dac_cs_n[1]) begin
    buf_r[{1'b1, dac_chan_addr}] = dac_data;
    wr_cnt++;
  end
  always @(posedge dac_load_strobe_n) begin
    out_r = buf_r;
    ld_cnt++;
  end
  assign amp_fault_flag = fault_req ? 1'b1 : 1'b0;
endmodule

// >>> pdwg_dac_glue_tb_top.sv
module pdwg_dac_glue_tb_top;
  import pdwg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        buffered_system_clock = 1'b0;
  logic        host_write_strobe_n = 1'b1;
  logic [15:0] host_addr = 16'h0;
  logic [15:0] host_data = 16'h0;
  logic        init_hold_n = 1'b0;
  logic        output_kind_strap_0 = 1'b0;
  logic        host_amp_select_n = 1'b1;
  logic        host_amp_enable_n = 1'b1;
  logic        fault_req = 1'b0;
  logic        amp_fault_flag;
  logic        write_ready;
  logic [1:0]  dac_cs_n;
  logic [1:0]  dac_chan_addr;
  logic [15:0] dac_data;
  logic        dac_load_strobe_n;
  logic        amp_serial_select_n;
  logic        amp_enable_n;
  logic        amp_fault_seen;
  logic [1:0]  output_kind;
  int          err_total = 0;
  int          comparisons = 0;
  int          n;
  pdwg_dac_glue pdwg_dac_glue_i (
    .ref_clk               (ref_clk),
    .rst_n                 (rst_n),
    .clk_en                (clk_en),
    .buffered_system_clock (buffered_system_clock),
    .host_write_strobe_n   (host_write_strobe_n),
    .host_addr             (host_addr),
    .host_data             (host_data),
    .init_hold_n           (init_hold_n),
    .output_kind_strap_0   (output_kind_strap_0),
    .host_amp_select_n     (host_amp_select_n),
    .host_amp_enable_n     (host_amp_enable_n),
    .amp_fault_flag        (amp_fault_flag),
    .write_ready           (write_ready),
    .dac_cs_n              (dac_cs_n),
    .dac_chan_addr         (dac_chan_addr),
    .dac_data              (dac_data),
    .dac_load_strobe_n     (dac_load_strobe_n),
    .amp_serial_select_n   (amp_serial_select_n),
    .amp_enable_n          (amp_enable_n),
    .amp_fault_seen        (amp_fault_seen),
    .output_kind           (output_kind)
  );
  pdwg_dac_model pdwg_dac_model_i (
    .dac_cs_n          (dac_cs_n),
    .dac_chan_addr     (dac_chan_addr),
    .dac_data          (dac_data),
    .dac_load_strobe_n (dac_load_strobe_n),
    .fault_req         (fault_req),
    .amp_fault_flag    (amp_fault_flag)
  );
  always #5 ref_clk = ~ref_clk;
  // ----
  // Tasks
  // ----
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Address held across the whole strobe window
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    host_addr = a;
    host_data = d;
    repeat (3) @(negedge ref_clk);
    host_write_strobe_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    buffered_system_clock = 1'b1;
    repeat (4) @(negedge ref_clk);
    buffered_system_clock = 1'b0;
    host_write_strobe_n = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask
  task wait_ld(input int target);
    for (int i = 0; i < 40000 && pdwg_dac_model_i.ld_cnt < target; i++) @(negedge ref_clk);
    if (pdwg_dac_model_i.ld_cnt < target) begin
      err_total++;
      $display("load wait ran out at %0t", $time);
      summarize();
    end
  endtask
  task t_hold;
    n = pdwg_dac_model_i.wr_cnt;
    chk(dac_cs_n, 16'h3);
    chk(output_kind, MODE_SERIAL_AMP);
    chk(amp_serial_select_n, 16'h1);
    wr(16'h4001, 16'h1111);
    repeat (20) @(negedge ref_clk);
    chk(16'(pdwg_dac_model_i.wr_cnt - n), 16'h0);
    init_hold_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    $display("hold test done");
  endtask
  // phase B written before phase A
  task t_axis1;
    n = pdwg_dac_model_i.ld_cnt;
    wr(16'h4001, 16'hb001);
    repeat (20) @(negedge ref_clk);
    chk(16'(pdwg_dac_model_i.ld_cnt - n), 16'h0);
    chk(pdwg_dac_model_i.buf_r[1], 16'hb001);
    wr(16'h4000, 16'ha001);
    wait_ld(n + 1);
    chk(pdwg_dac_model_i.out_r[0], 16'ha001);
    chk(pdwg_dac_model_i.out_r[1], 16'hb001);
    $display("axis test done");
  endtask
  // Gap holds the queue, so phase B writes fill it
  task t_fill;
    n = pdwg_dac_model_i.wr_cnt;
    for (int i = 0; i < 17; i++) wr(16'h4003, 16'(16'hc000 + i));
    chk(write_ready, 16'h0);
    repeat (LOAD_GAP_CYC + 400) @(negedge ref_clk);
    chk(write_ready, 16'h1);
    chk(16'(pdwg_dac_model_i.wr_cnt - n), 16'h10);
    chk(pdwg_dac_model_i.buf_r[3], 16'hc00f);
    $display("fill test done");
  endtask
  task t_axes;
    n = pdwg_dac_model_i.ld_cnt;
    for (int a = 1; a < 4; a++) begin
      wr(16'(16'h4001 + 2 * a), 16'(16'hb000 + a));
      wr(16'(16'h4000 + 2 * a), 16'(16'ha000 + a));
    end
    wait_ld(n + 3);
    repeat (50) @(negedge ref_clk);
    chk(16'(pdwg_dac_model_i.ld_cnt - n), 16'h3);
    for (int a = 1; a < 4; a++) begin
      chk(pdwg_dac_model_i.out_r[2 * a], 16'(16'ha000 + a));
      chk(pdwg_dac_model_i.out_r[2 * a + 1], 16'(16'hb000 + a));
    end
    n = pdwg_dac_model_i.wr_cnt;
    wr(16'h0005, 16'h5555);
    repeat (20) @(negedge ref_clk);
    chk(16'(pdwg_dac_model_i.wr_cnt - n), 16'h0);
    $display("multi axis test done");
  endtask
  task t_amp;
    host_amp_select_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk(amp_serial_select_n, 16'h0);
    host_amp_enable_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk(amp_enable_n, 16'h0);
    fault_req = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk(amp_fault_seen, 16'h1);
    chk(amp_enable_n, 16'h1);
    fault_req = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk(amp_fault_seen, 16'h0);
    chk(amp_enable_n, 16'h0);
    host_amp_select_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk(amp_serial_select_n, 16'h1);
    // Frozen enable keeps the select where it was
    clk_en = 1'b0;
    host_amp_select_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk(amp_serial_select_n, 16'h1);
    clk_en = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk(amp_serial_select_n, 16'h0);
    // Strap high in hold picks the parallel path and drops the select
    output_kind_strap_0 = 1'b1;
    init_hold_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk(output_kind, MODE_PARALLEL_DAC);
    chk(amp_serial_select_n, 16'h1);
    output_kind_strap_0 = 1'b0;
    repeat (5) @(negedge ref_clk);
    init_hold_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk(output_kind, MODE_SERIAL_AMP);
    chk(amp_serial_select_n, 16'h0);
    host_amp_select_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    $display("amplifier test done");
  endtask
  initial begin
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_hold();
    t_axis1();
    t_fill();
    t_axes();
    t_amp();
    summarize();
  end
endmodule
